// File: core/lssc_defines.vh
// Offsets, field positions, reset values and timing counts for link status / slot capabilities
`ifndef LSSC_DEFINES_VH
`define LSSC_DEFINES_VH

`define LSSC_ADDR_W 8
`define LSSC_OFF_LINK_STATUS 8'hD0
`define LSSC_OFF_SLOT_CAP 8'hD4
// Own register: override of the slot clock default, with override flag
`define LSSC_OFF_CFG_LOAD 8'hE0
// Own register: message counter and port role
`define LSSC_OFF_MSG_STAT 8'hE4

// Link status fields (bit positions in the 32-bit word)
`define LSSC_LS_SPEED_LSB 16
`define LSSC_LS_WIDTH_LSB 20
`define LSSC_LS_TERR_BIT 26
`define LSSC_LS_TRAIN_BIT 27
`define LSSC_LS_SCLK_BIT 28
`define LSSC_LS_DLACT_BIT 29

// Slot capability fields
`define LSSC_SC_ABP_BIT 0
`define LSSC_SC_PCP_BIT 1
`define LSSC_SC_AIP_BIT 3
`define LSSC_SC_PIP_BIT 4
`define LSSC_SC_HPS_BIT 5
`define LSSC_SC_HPC_BIT 6
`define LSSC_SC_SPLV_LSB 7
`define LSSC_SC_SPLS_LSB 15
`define LSSC_SC_PSN_LSB 19

// Reset values and the two supported link speed codes
`define LSSC_RST_SPEED 4'h2
`define LSSC_SPEED_2G5 4'h1
`define LSSC_SPEED_5G0 4'h2
`define LSSC_RST_WIDTH 6'h01
`define LSSC_RST_SPLV 8'h00
`define LSSC_RST_SPLS 2'h0
`define LSSC_RST_PSN 13'h0000
`define LSSC_RST_CAPS 6'h00

// Cycles the power limit message request is held for the transmitter
`define LSSC_MSG_PULSE 2'h1

`endif

// File: core/lssc_sync.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none

module lssc_sync
(
   input wire clk,
   input wire rst,
   input wire d_in,
   output wire q_out
);

   reg meta_ff;
   reg sync_ff;

   // First stage feeds only the second stage
   always @(posedge clk)
   begin
      if (rst)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= d_in;
         sync_ff <= meta_ff;
      end
   end

   assign q_out = sync_ff;

endmodule // lssc_sync

`default_nettype wire

// File: core/lssc_regs.v
// Link status and slot capabilities register bank for one switch port
// Function
// - Link speed read-only 4-bit field, 0001b 2.5G, 0010b 5.0G, reset 0010b.
// - Negotiated width read-only 6-bit field, 0001b means x1, reset 0001b.
// - Training error flag set when link training fails, reset zero.
// - Training error flag cleared by hardware on successful training to L0.
// - Training-in-progress flag high while training runs, cleared when done.
// - Slot clock bit: zero independent clock, one platform reference clock.
// - Slot clock bit loaded from strap on the third edge after reset release, overridable by side-band load.
// - Data-link-active bit is one in DL_Active, zero otherwise, reset zero.
// - Slot capabilities register exists only on downstream ports.
// - Attention button present bit, read-only, reset zero.
// - Power controller present bit, read-only, reset zero.
// - Attention indicator present bit, read-only, reset zero.
// - Power indicator present bit, read-only, reset zero.
// - Hot-plug surprise bit, read-only, reset zero.
// - Hot-plug capable bit, read-only, reset zero.
// - Writable 8-bit slot power limit value, reset 00h; write sends message.
// - Writable 2-bit power limit scale, reset 00b; write sends message.
// - Physical slot number read-only 13-bit field, reset 0000h.
// - Capability defaults replaceable by side-band load after reset.
`timescale 1ns/10ps
`default_nettype none
`include "lssc_defines.vh"

module lssc_regs
(
   input wire clk,
   input wire rst,
   // Register port
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   // Port role, static strap
   input wire downstream_port,
   // Link layer status, same clock domain
   input wire [3:0] link_speed_in,
   input wire [5:0] link_width_in,
   input wire train_active_in,
   input wire train_fail_in,
   input wire link_l0_in,
   input wire dl_active_in,
   // Slot clock strap pin, asynchronous
   input wire slot_clock_strap,
   // Side-band default load (SMBus or EEPROM engine), same clock
   input wire sb_load,
   input wire [31:0] sb_slot_cap,
   input wire sb_clk_cfg,
   input wire sb_clk_load,
   // Power limit message request to the transmitter
   output reg spl_msg_req,
   output reg [7:0] spl_msg_value,
   output reg [1:0] spl_msg_scale
);

   // Decode helper, used for several registers
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // Synchronised strap
   wire strap_sync;

   lssc_sync u_strap_sync
   (
      .clk(clk),
      .rst(rst),
      .d_in(slot_clock_strap),
      .q_out(strap_sync)
   );

   // Link status fields, read at D0h
   reg [3:0] speed_ff;
   reg [5:0] width_ff;
   reg terr_ff;
   reg train_ff;
   reg sclk_ff;
   reg dlact_ff;

   // Strap capture and override tracking
   reg strap_taken_ff;
   reg sclk_override_ff;

   // Slot capability fields, read at D4h
   reg [5:0] caps_ff;
   reg [7:0] splv_ff;
   reg [1:0] spls_ff;
   reg [12:0] psn_ff;

   // Message count and strap settle delay
   reg [7:0] msg_cnt_ff;
   reg [1:0] strap_wait_ff;

   // Next values from the combinational processes
   reg [3:0] nxt_speed;
   reg [5:0] nxt_width;
   reg nxt_terr;
   reg nxt_train;
   reg nxt_dlact;
   reg [31:0] nxt_rdata;

   // Address decode, one wire per mapped register
   wire hit_ls;
   wire hit_sc;
   wire hit_cfg;
   wire hit_stat;

   assign hit_ls = hit(reg_addr, `LSSC_OFF_LINK_STATUS);
   assign hit_sc = hit(reg_addr, `LSSC_OFF_SLOT_CAP);
   assign hit_cfg = hit(reg_addr, `LSSC_OFF_CFG_LOAD);
   assign hit_stat = hit(reg_addr, `LSSC_OFF_MSG_STAT);

   // Decoded write strobes
   wire wr_cap;
   wire wr_cfg;
   wire msg_fire;

   // Capability writes only land on downstream ports
   assign wr_cap = reg_wr & hit_sc & downstream_port;
   assign wr_cfg = reg_wr & hit_cfg;
   // Side-band load wins over a same-cycle write, so it also blocks the message
   assign msg_fire = wr_cap & ~sb_load;

   // Training settled in L0: latch point for speed and width, clear point for the error
   wire train_done;
   wire strap_ready;

   assign train_done = link_l0_in & ~train_active_in;
   // Synchroniser output is trustworthy only from the third edge after release
   assign strap_ready = (strap_wait_ff == 2'h2);

   // Link status next-state logic
   always @*
   begin
      nxt_speed = speed_ff;
      nxt_width = width_ff;
      nxt_train = train_active_in;
      nxt_dlact = dl_active_in;
      nxt_terr = terr_ff;
      // Speed and width only latch after training settles, so the
      // register never shows a half-negotiated value
      if (train_done)
      begin
         if (link_speed_in == `LSSC_SPEED_2G5 || link_speed_in == `LSSC_SPEED_5G0)
         begin
            nxt_speed = link_speed_in;
         end
         nxt_width = link_width_in;
      end
      // Failure wins over success in the same cycle so an error is not lost
      if (train_done)
      begin
         nxt_terr = 1'b0;
      end
      if (train_fail_in)
      begin
         nxt_terr = 1'b1;
      end
   end

   // Link status registers
   // Training and link-active bits are plain mirrors, one cycle behind the link layer
   always @(posedge clk)
   begin
      if (rst)
      begin
         speed_ff <= `LSSC_RST_SPEED;
         width_ff <= `LSSC_RST_WIDTH;
         terr_ff <= 1'b0;
         train_ff <= 1'b0;
         dlact_ff <= 1'b0;
      end
      else
      begin
         speed_ff <= nxt_speed;
         width_ff <= nxt_width;
         terr_ff <= nxt_terr;
         train_ff <= nxt_train;
         dlact_ff <= nxt_dlact;
      end
   end

   // Strap capture: the synchroniser needs two edges after release
   // before it reflects the pin, so capture on the third
   always @(posedge clk)
   begin
      if (rst)
      begin
         strap_wait_ff <= 2'h0;
         strap_taken_ff <= 1'b0;
         sclk_ff <= 1'b0;
         sclk_override_ff <= 1'b0;
      end
      else
      begin
         if (!strap_ready)
         begin
            strap_wait_ff <= strap_wait_ff + 2'h1;
         end
         // Side-band load beats a same-cycle E0h write; either cancels the strap capture
         if (sb_clk_load)
         begin
            sclk_ff <= sb_clk_cfg;
            sclk_override_ff <= 1'b1;
            strap_taken_ff <= 1'b1;
         end
         else if (wr_cfg)
         begin
            sclk_ff <= reg_wdata[`LSSC_LS_SCLK_BIT];
            sclk_override_ff <= 1'b1;
            strap_taken_ff <= 1'b1;
         end
         else if (!strap_taken_ff && strap_ready)
         begin
            sclk_ff <= strap_sync;
            strap_taken_ff <= 1'b1;
         end
      end
   end

   // Slot capability fields and side-band default loading
   always @(posedge clk)
   begin
      if (rst)
      begin
         caps_ff <= `LSSC_RST_CAPS;
         splv_ff <= `LSSC_RST_SPLV;
         spls_ff <= `LSSC_RST_SPLS;
         psn_ff <= `LSSC_RST_PSN;
      end
      else if (sb_load)
      begin
         // Side-band load replaces defaults; reserved bits are dropped
         caps_ff <= {sb_slot_cap[`LSSC_SC_HPC_BIT], sb_slot_cap[`LSSC_SC_HPS_BIT],
            sb_slot_cap[`LSSC_SC_PIP_BIT], sb_slot_cap[`LSSC_SC_AIP_BIT],
            sb_slot_cap[`LSSC_SC_PCP_BIT], sb_slot_cap[`LSSC_SC_ABP_BIT]};
         splv_ff <= sb_slot_cap[`LSSC_SC_SPLV_LSB +: 8];
         spls_ff <= sb_slot_cap[`LSSC_SC_SPLS_LSB +: 2];
         psn_ff <= sb_slot_cap[`LSSC_SC_PSN_LSB +: 13];
      end
      else if (wr_cap)
      begin
         // Only value and scale are writable; all else ignores the write
         splv_ff <= reg_wdata[`LSSC_SC_SPLV_LSB +: 8];
         spls_ff <= reg_wdata[`LSSC_SC_SPLS_LSB +: 2];
      end
   end

   // Power limit message: one-cycle request carrying the written values.
   // A side-band load is a default change, not a software write, so no message.
   always @(posedge clk)
   begin
      if (rst)
      begin
         spl_msg_req <= 1'b0;
         spl_msg_value <= `LSSC_RST_SPLV;
         spl_msg_scale <= `LSSC_RST_SPLS;
      end
      else
      begin
         spl_msg_req <= msg_fire;
         if (msg_fire)
         begin
            spl_msg_value <= reg_wdata[`LSSC_SC_SPLV_LSB +: 8];
            spl_msg_scale <= reg_wdata[`LSSC_SC_SPLS_LSB +: 2];
         end
      end
   end

   // Message counter for software; wraps silently, so it only shows activity
   always @(posedge clk)
   begin
      if (rst)
      begin
         msg_cnt_ff <= 8'h00;
      end
      else if (msg_fire)
      begin
         msg_cnt_ff <= msg_cnt_ff + 8'h01;
      end
   end

   // Read mux; unmapped addresses and reserved bits return zero
   always @*
   begin
      nxt_rdata = 32'h00000000;
      if (hit_ls)
      begin
         nxt_rdata[`LSSC_LS_SPEED_LSB +: 4] = speed_ff;
         nxt_rdata[`LSSC_LS_WIDTH_LSB +: 6] = width_ff;
         nxt_rdata[`LSSC_LS_TERR_BIT] = terr_ff;
         nxt_rdata[`LSSC_LS_TRAIN_BIT] = train_ff;
         nxt_rdata[`LSSC_LS_SCLK_BIT] = sclk_ff;
         nxt_rdata[`LSSC_LS_DLACT_BIT] = dlact_ff;
      end
      else if (hit_sc && downstream_port)
      begin
         nxt_rdata[`LSSC_SC_ABP_BIT] = caps_ff[0];
         nxt_rdata[`LSSC_SC_PCP_BIT] = caps_ff[1];
         nxt_rdata[`LSSC_SC_AIP_BIT] = caps_ff[2];
         nxt_rdata[`LSSC_SC_PIP_BIT] = caps_ff[3];
         nxt_rdata[`LSSC_SC_HPS_BIT] = caps_ff[4];
         nxt_rdata[`LSSC_SC_HPC_BIT] = caps_ff[5];
         nxt_rdata[`LSSC_SC_SPLV_LSB +: 8] = splv_ff;
         nxt_rdata[`LSSC_SC_SPLS_LSB +: 2] = spls_ff;
         nxt_rdata[`LSSC_SC_PSN_LSB +: 13] = psn_ff;
      end
      // Own registers: override status and message count
      else if (hit_cfg)
      begin
         nxt_rdata[`LSSC_LS_SCLK_BIT] = sclk_ff;
         nxt_rdata[0] = sclk_override_ff;
      end
      else if (hit_stat)
      begin
         nxt_rdata[7:0] = msg_cnt_ff;
         nxt_rdata[8] = downstream_port;
      end
   end

   // Read data valid only the cycle after the strobe
   // Zero between reads so a stale word never looks like a fresh answer
   always @(posedge clk)
   begin
      if (rst)
      begin
         reg_rdata <= 32'h00000000;
      end
      else if (reg_rd)
      begin
         reg_rdata <= nxt_rdata;
      end
      else
      begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // lssc_regs

`default_nettype wire

// File: test/lssc_regs_properties.sv
// Checker for the link status and slot capabilities register bank
`timescale 1ns/10ps
`default_nettype none

module lssc_regs_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic downstream_port,
   input wire logic train_active_in,
   input wire logic train_fail_in,
   input wire logic dl_active_in,
   input wire logic sb_load,
   input wire logic spl_msg_req,
   input wire logic [7:0] spl_msg_value,
   input wire logic [1:0] spl_msg_scale
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Qualifiers of a taken request; link inputs need two cycles to reach read data
   wire cap_wr = reg_wr && reg_addr == 8'hD4 && downstream_port && !sb_load;
   // Read strobe and port role as the design saw them one edge back
   logic rd_ls_ff;
   logic rd_sc_ff;
   logic dsp_ff;
   always @(posedge clk)
   begin
      rd_ls_ff <= reg_rd && reg_addr == 8'hD0;
      rd_sc_ff <= reg_rd && reg_addr == 8'hD4;
      dsp_ff <= downstream_port;
   end

   a_msg_value: assert property (cap_wr |=>
      spl_msg_req && spl_msg_value == $past(reg_wdata[14:7]))
      else $error("power limit value message wrong");
   a_msg_scale: assert property (cap_wr |=> spl_msg_scale == $past(reg_wdata[16:15]))
      else $error("power limit scale message wrong");
   a_msg_cause: assert property (spl_msg_req |-> $past(cap_wr))
      else $error("message without a capability write");
   a_upstream_zero: assert property (rd_sc_ff && !dsp_ff |-> reg_rdata == 32'h0)
      else $error("upstream port shows slot capabilities");
   a_rsvd_status: assert property (rd_ls_ff |-> reg_rdata[31:30] == 2'h0)
      else $error("reserved link status bits set");
   a_rsvd_cap: assert property (rd_sc_ff |-> reg_rdata[18:17] == 2'h0 && !reg_rdata[2])
      else $error("reserved slot capability bits set");
   a_dl_mirror: assert property (rd_ls_ff |->
      reg_rdata[29] == $past(dl_active_in, 2))
      else $error("link active bit does not follow");
   a_train_mirror: assert property (rd_ls_ff |->
      reg_rdata[27] == $past(train_active_in, 2))
      else $error("training bit does not follow");
   a_err_set: assert property (rd_ls_ff && $past(train_fail_in, 2) |-> reg_rdata[26])
      else $error("training error not flagged");

   // Main scenarios
   c_msg: cover property (cap_wr ##1 spl_msg_req);
   c_up: cover property (rd_sc_ff && !dsp_ff);
   c_err: cover property (rd_ls_ff && $past(train_fail_in, 2));
endmodule // lssc_regs_chk

bind lssc_regs lssc_regs_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .downstream_port(downstream_port), .train_active_in(train_active_in),
   .train_fail_in(train_fail_in), .dl_active_in(dl_active_in), .sb_load(sb_load),
   .spl_msg_req(spl_msg_req), .spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale));

`default_nettype wire

// File: test/lssc_regs_tb_top.sv
// Directed testbench for the link status and slot capabilities register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end

module lssc_regs_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, sb_slot_cap = 32'h0, rd_val;
   logic reg_wr = 1'b0, reg_rd = 1'b0, downstream_port = 1'b1, train_active_in = 1'b0;
   logic [3:0] link_speed_in = 4'h1;
   logic [5:0] link_width_in = 6'h04;
   logic train_fail_in = 1'b0, link_l0_in = 1'b0, dl_active_in = 1'b0, slot_clock_strap = 1'b1;
   logic sb_load = 1'b0, sb_clk_cfg = 1'b1, sb_clk_load = 1'b0, spl_msg_req;
   logic [7:0] spl_msg_value;
   logic [1:0] spl_msg_scale;
   int num_errors = 0, n_compared = 0, cycles = 0;

   lssc_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .downstream_port(downstream_port), .link_speed_in(link_speed_in),
      .link_width_in(link_width_in), .train_active_in(train_active_in),
      .train_fail_in(train_fail_in), .link_l0_in(link_l0_in), .dl_active_in(dl_active_in),
      .slot_clock_strap(slot_clock_strap), .sb_load(sb_load), .sb_slot_cap(sb_slot_cap),
      .sb_clk_cfg(sb_clk_cfg), .sb_clk_load(sb_clk_load), .spl_msg_req(spl_msg_req),
      .spl_msg_value(spl_msg_value), .spl_msg_scale(spl_msg_scale));

   // 250 MHz clock
   initial
   begin
      forever #2 clk = ~clk;
   end

   // Hang guard, the sequence needs about a hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One-cycle write strobe, released at the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe: sample just past that edge,
   // then return on an edge so the caller's drives stay edge-aligned
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
      @(posedge clk);
   endtask

   // Message outputs {req, value, scale}, looked at just past an edge
   task automatic chk_msg(input logic [10:0] e);
      #1;
      `CHK({spl_msg_req, spl_msg_value, spl_msg_scale}, e)
      @(posedge clk);
   endtask

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      cyc(20);
      rst <= 1'b0;
      cyc(5);
      rd(8'hD0, 32'h1012_0000);
      rd(8'hD4, 32'h0000_0000);
      wr(8'hD4, 32'hFFFF_FFFF);
      chk_msg(11'h7FF);
      rd(8'hD4, 32'h0001_FF80);
      wr(8'hD4, 32'h0000_0000);
      chk_msg(11'h400);
      sb_slot_cap <= 32'hFFFF_FFFF;
      sb_load <= 1'b1;
      cyc(1);
      sb_load <= 1'b0;
      rd(8'hD4, 32'hFFF9_FFFB);
      chk_msg(11'h000);
      link_l0_in <= 1'b1;
      dl_active_in <= 1'b1;
      cyc(3);
      rd(8'hD0, 32'h3041_0000);
      link_l0_in <= 1'b0;
      train_active_in <= 1'b1;
      train_fail_in <= 1'b1;
      cyc(3);
      rd(8'hD0, 32'h3C41_0000);
      train_fail_in <= 1'b0;
      train_active_in <= 1'b0;
      link_l0_in <= 1'b1;
      link_speed_in <= 4'h2;
      dl_active_in <= 1'b0;
      cyc(3);
      rd(8'hD0, 32'h1042_0000);
      wr(8'hE0, 32'h0000_0000);
      rd(8'hD0, 32'h0042_0000);
      sb_clk_load <= 1'b1;
      cyc(1);
      sb_clk_load <= 1'b0;
      rd(8'hD0, 32'h1042_0000);
      wr(8'hD0, 32'hFFFF_FFFF);
      wr(8'h10, 32'hFFFF_FFFF);
      rd(8'h10, 32'h0000_0000);
      rd(8'hD0, 32'h1042_0000);
      downstream_port <= 1'b0;
      cyc(2);
      wr(8'hD4, 32'h0000_1234);
      chk_msg(11'h000);
      rd(8'hD4, 32'h0000_0000);
      downstream_port <= 1'b1;
      cyc(2);
      rd(8'hD4, 32'hFFF9_FFFB);
      rd(8'hE0, 32'h1000_0001);
      rd(8'hE4, 32'h0000_0102);
      give_verdict();
   end
endmodule // lssc_regs_tb_top

`default_nettype wire
